// ===== hdl/reset_and_startup_control.v
// Reset controller with cause flags and start-up delay.
// How it works
// - Pin reset in normal mode, pin reset in halt, watchdog in normal mode: full reset.
// - Watchdog in halt resets only program counter and stack pointer.
// - Power-up leaves timeout and powerdown flags at zero.
// - Pin reset in normal mode keeps both flags.
// - Watchdog in normal mode sets timeout, keeps powerdown.
// - Power-up holds execution 2048 system clocks; wake-up holds it 1024.
// - Power-up adds an extra delay; wake-up only the start-up delay.
// - Full reset: pc zero, interrupts off, dividers cleared, timers off, ports input.
// - Full reset clears watchdog, clock and time-base counters; watchdog restarts after.
// - Full resets load listed register values; warm reset leaves them.
// - Bits unknown after reset are not initialised.
// - Most registers reset on any reset; some keep on non-power-on resets.
// - Powerdown flag cleared by power-up or watchdog clear, set by halt.
// - Entering halt sets powerdown flag and clears timeout flag.
`timescale 1ns/1ps
`default_nettype none
`include "reset_ctrl_consts.vh"

module reset_and_startup_control (
   input  wire        clk_in,
   input  wire        rst_in,
   input  wire        ext_reset_pin_n_in,
   input  wire        watchdog_timeout_in,
   input  wire        halt_exec_in,
   input  wire        watchdog_clear_exec_in,
   input  wire        wake_event_in,
   output reg         timeout_flag_out,
   output reg         powerdown_flag_out,
   output reg         halted_out,
   output reg         core_reset_out,
   output reg         full_reset_out,
   output reg         warm_reset_out,
   output reg         watchdog_clear_out,
   output reg  [11:0] pc_reset_value_out,
   output reg  [2:0]  stack_pointer_out,
   output reg  [7:0]  timer0_control_out,
   output reg  [7:0]  converter_control_out,
   output reg  [7:0]  port_dir_out,
   output reg         int_enable_clear_out
);

   localparam ST_POWERUP = 2'h0;
   localparam ST_STARTUP = 2'h1;
   localparam ST_RUN     = 2'h2;
   localparam ST_HALT    = 2'h3;

   reg [1:0]                  state;
   reg [`STARTUP_WIDTH-1:0]   count;
   reg                        pin_meta;
   reg                        pin_sync_n;

   // ------------------------------------------------------------
   // Pin synchroniser
   // ------------------------------------------------------------
   // Two flops settle the asynchronous pin before the sequencer reads it.
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         pin_meta   <= 1'b1;
         pin_sync_n <= 1'b1;
      end else begin
         pin_meta   <= ext_reset_pin_n_in;
         pin_sync_n <= pin_meta;
      end
   end

   // ------------------------------------------------------------
   // Counter helpers
   // ------------------------------------------------------------
   // True on the last cycle of a power-up or start-up delay.
   function count_last;
      input [`STARTUP_WIDTH-1:0] value;
      begin
         count_last = (value == `STARTUP_LAST);
      end
   endfunction

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state                 <= ST_POWERUP;
         count                 <= `POWERUP_EXTRA_CYCLES;
         timeout_flag_out      <= 1'b0;
         powerdown_flag_out    <= 1'b0;
         halted_out            <= 1'b0;
         core_reset_out        <= 1'b1;
         full_reset_out        <= 1'b1;
         warm_reset_out        <= 1'b0;
         watchdog_clear_out    <= 1'b1;
         pc_reset_value_out    <= `PC_RESET;
         stack_pointer_out     <= `SP_RESET;
         timer0_control_out    <= `TIMER0_CTRL_RESET;
         converter_control_out <= `CONVERTER_CTRL_RESET;
         port_dir_out          <= `PORT_DIR_INPUT;
         int_enable_clear_out  <= 1'b1;
      end else begin
         warm_reset_out <= 1'b0;
         case (state)
            ST_POWERUP: begin
               if (count_last(count)) begin
                  state <= ST_STARTUP;
                  count <= `STARTUP_CYCLES;
               end else begin
                  count <= count - 1'b1;
               end
            end
            ST_STARTUP: begin
               // Events are ignored until the hold ends.
               // hold reset for start-up delay
               if (count_last(count)) begin
                  state                <= ST_RUN;
                  core_reset_out       <= 1'b0;
                  full_reset_out       <= 1'b0;
                  watchdog_clear_out   <= 1'b0;
                  int_enable_clear_out <= 1'b0;
               end else begin
                  count <= count - 1'b1;
               end
            end
            ST_RUN: begin
               if (~pin_sync_n) begin
                  core_reset_out       <= 1'b1;
                  full_reset_out       <= 1'b1;
                  watchdog_clear_out   <= 1'b1;
                  int_enable_clear_out <= 1'b1;
                  pc_reset_value_out    <= `PC_RESET;
                  stack_pointer_out     <= `SP_RESET;
                  timer0_control_out    <= `TIMER0_CTRL_RESET;
                  converter_control_out <= `CONVERTER_CTRL_RESET;
                  port_dir_out          <= `PORT_DIR_INPUT;
                  state                 <= ST_STARTUP;
                  count                 <= `STARTUP_CYCLES;
               end else if (watchdog_timeout_in) begin
                  timeout_flag_out      <= 1'b1;
                  core_reset_out        <= 1'b1;
                  full_reset_out        <= 1'b1;
                  watchdog_clear_out    <= 1'b1;
                  int_enable_clear_out  <= 1'b1;
                  pc_reset_value_out    <= `PC_RESET;
                  stack_pointer_out     <= `SP_RESET;
                  timer0_control_out    <= `TIMER0_CTRL_RESET;
                  converter_control_out <= `CONVERTER_CTRL_RESET;
                  port_dir_out          <= `PORT_DIR_INPUT;
                  state                 <= ST_STARTUP;
                  count                 <= `STARTUP_CYCLES;
               end else if (halt_exec_in) begin
                  powerdown_flag_out <= 1'b1;
                  timeout_flag_out   <= 1'b0;
                  halted_out         <= 1'b1;
                  watchdog_clear_out <= 1'b1;
                  state              <= ST_HALT;
               end else begin
                  watchdog_clear_out <= 1'b0;
                  if (watchdog_clear_exec_in) begin
                     powerdown_flag_out <= 1'b0;
                     timeout_flag_out   <= 1'b0;
                  end
               end
            end
            ST_HALT: begin
               // The pin outranks the watchdog, which outranks a wake event.
               watchdog_clear_out <= 1'b0;
               if (~pin_sync_n) begin
                  timeout_flag_out      <= 1'b0;
                  powerdown_flag_out    <= 1'b1;
                  halted_out            <= 1'b0;
                  core_reset_out        <= 1'b1;
                  full_reset_out        <= 1'b1;
                  watchdog_clear_out    <= 1'b1;
                  int_enable_clear_out  <= 1'b1;
                  pc_reset_value_out    <= `PC_RESET;
                  stack_pointer_out     <= `SP_RESET;
                  timer0_control_out    <= `TIMER0_CTRL_RESET;
                  converter_control_out <= `CONVERTER_CTRL_RESET;
                  port_dir_out          <= `PORT_DIR_INPUT;
                  state                 <= ST_STARTUP;
                  count                 <= `STARTUP_CYCLES;
               end else if (watchdog_timeout_in) begin
                  // Only the fetch address and stack pointer reload here.
                  // warm reset, registers kept
                  timeout_flag_out   <= 1'b1;
                  powerdown_flag_out <= 1'b1;
                  halted_out         <= 1'b0;
                  core_reset_out     <= 1'b1;
                  warm_reset_out     <= 1'b1;
                  pc_reset_value_out <= `PC_RESET;
                  stack_pointer_out  <= `SP_RESET;
                  state              <= ST_STARTUP;
                  count              <= `STARTUP_CYCLES;
               end else if (wake_event_in) begin
                  halted_out     <= 1'b0;
                  core_reset_out <= 1'b1;
                  state          <= ST_STARTUP;
                  count          <= `STARTUP_CYCLES;
               end
            end
            default: begin
               state <= ST_POWERUP;
               count <= `POWERUP_EXTRA_CYCLES;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// ===== shared/reset_ctrl_consts.vh
// Constants for the reset and start-up controller.
`ifndef RESET_CTRL_CONSTS_VH
`define RESET_CTRL_CONSTS_VH
// Start-up delay in system clock cycles, and the counter width that holds it.
`define STARTUP_CYCLES       11'h400
`define STARTUP_WIDTH        11
// Counter value on the last cycle of a delay.
`define STARTUP_LAST         11'h001
// Extra power-up delay on top of the start-up delay.
`define POWERUP_EXTRA_CYCLES 11'h400
// Reset values of the registers this block presets.
`define PC_RESET             12'h000
`define SP_RESET             3'h0
`define TIMER0_CTRL_RESET    8'h08
`define CONVERTER_CTRL_RESET 8'h40
`define PORT_DIR_INPUT       8'hff
`endif

// ===== tb/rsc_checker.sv
// Port assertions for the reset and start-up controller.
`timescale 1ns/1ps
`default_nettype none
module rsc_checker (
   input wire logic        clk_in,
   input wire logic        rst_in,
   input wire logic        ext_reset_pin_n_in,
   input wire logic        watchdog_timeout_in,
   input wire logic        halt_exec_in,
   input wire logic        timeout_flag_out,
   input wire logic        powerdown_flag_out,
   input wire logic        halted_out,
   input wire logic        core_reset_out,
   input wire logic        full_reset_out,
   input wire logic        warm_reset_out,
   input wire logic        int_enable_clear_out,
   input wire logic [11:0] pc_reset_value_out,
   input wire logic [7:0]  timer0_control_out,
   input wire logic [7:0]  converter_control_out,
   input wire logic [7:0]  port_dir_out
);
   logic [11:0] boot_cnt;
   logic        booting;
   logic [11:0] hold_cnt;
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // Counts cycles from power-on release until the core is let go.
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         boot_cnt <= 12'h000;
         booting  <= 1'b1;
      end else if (booting) begin
         boot_cnt <= boot_cnt + 12'h001;
         booting  <= core_reset_out;
      end
   end
   // Counts the cycles of each core hold, too long for a delay range.
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         hold_cnt <= 12'h000;
      end else if (core_reset_out) begin
         hold_cnt <= hold_cnt + 12'h001;
      end else begin
         hold_cnt <= 12'h000;
      end
   end
   // The design acts on the pin level it sampled two edges earlier.
   boot_flags_a: assert property ($past(rst_in) |-> !timeout_flag_out && !powerdown_flag_out)
      else $error("flags not clear after power-up");
   boot_delay_a:
      assert property (booting && !core_reset_out |-> boot_cnt == 12'd2048)
      else $error("power-up hold length wrong");
   halt_entry_a:
      assert property (halt_exec_in && !halted_out && !core_reset_out && !watchdog_timeout_in
         && $past(ext_reset_pin_n_in, 2) |=> halted_out && powerdown_flag_out
         && !timeout_flag_out) else $error("halt entry flags wrong");
   warm_wake_a:
      assert property (watchdog_timeout_in && halted_out && $past(ext_reset_pin_n_in, 2)
         |=> warm_reset_out && !full_reset_out && !int_enable_clear_out && timeout_flag_out
         && powerdown_flag_out && $stable(timer0_control_out)
         && $stable(converter_control_out) && $stable(port_dir_out))
      else $error("warm wake wrong");
   wd_full_a:
      assert property (watchdog_timeout_in && !halted_out && !core_reset_out
         && $past(ext_reset_pin_n_in, 2)
         |=> full_reset_out && timeout_flag_out && $stable(powerdown_flag_out))
      else $error("watchdog reset wrong");
   pin_full_a:
      assert property (!ext_reset_pin_n_in ##2 !core_reset_out |=> core_reset_out && full_reset_out)
      else $error("pin reset not taken");
   pin_keep_a:
      assert property (!ext_reset_pin_n_in ##2 (!core_reset_out && !halted_out)
         |=> $stable(timeout_flag_out) && $stable(powerdown_flag_out))
      else $error("pin reset changed flags");
   pin_wake_a:
      assert property (!ext_reset_pin_n_in ##2 (!core_reset_out && halted_out)
         |=> !timeout_flag_out && powerdown_flag_out && !halted_out)
      else $error("pin wake flags wrong");
   start_hold_a:
      assert property ($fell(core_reset_out) && !booting |-> hold_cnt == 12'd1024)
      else $error("start-up hold length wrong");
   full_vals_a:
      assert property (full_reset_out && $past(full_reset_out) |-> pc_reset_value_out == 12'h000
         && timer0_control_out == 8'h08 && converter_control_out == 8'h40
         && port_dir_out == 8'hff && int_enable_clear_out) else $error("reset values wrong");
   warm_c: cover property (warm_reset_out);
   pin_c: cover property (!ext_reset_pin_n_in && !core_reset_out);
   hold_c: cover property ($fell(core_reset_out));
endmodule
`default_nettype wire

// ===== tb/ext_reset_drv.sv
// Model of the external circuit that pulls the reset pin low.
`timescale 1ns/1ps
`default_nettype none
module ext_reset_drv #(parameter int HOLD = 8) (
   input  wire logic clk_in,
   input  wire logic req_in,
   output wire logic pin_n_out
);
   int cnt = 0;
   always @(posedge clk_in) begin
      if (req_in) cnt <= HOLD;
      else if (cnt > 0) cnt <= cnt - 1;
   end
   // The released pin is pulled up.
   assign pin_n_out = (cnt == 0);
endmodule
`default_nettype wire

// ===== tb/tb_reset_and_startup_control.sv
// Self-checking bench for the reset and start-up controller.
`timescale 1ns/1ps
`default_nettype none
module tb_reset_and_startup_control;
   logic        clk_in, rst_in, wd, halt, wclr, wake, pin_req, pin_n, to, pd, halted, core_rst;
   logic [11:0] pc;
   logic        wdclr;
   logic [2:0]  sp;
   logic [7:0]  t0c, cvc, pdir;
   int          error_cnt = 0, cmp_count = 0, i, n;
   // Rows: halt first, event (0 watchdog, 1 pin, 2 wake, 3 clear), expected timeout, powerdown.
   logic [4:0]  rows [0:6] = '{5'b00010, 5'b10011, 5'b10101, 5'b00101, 5'b00011, 5'b11001,
                               5'b01100};
   reset_and_startup_control i_dut (.clk_in(clk_in), .rst_in(rst_in), .ext_reset_pin_n_in(pin_n),
      .watchdog_timeout_in(wd), .halt_exec_in(halt), .watchdog_clear_exec_in(wclr),
      .wake_event_in(wake), .timeout_flag_out(to), .powerdown_flag_out(pd),
      .halted_out(halted), .core_reset_out(core_rst), .full_reset_out(), .warm_reset_out(),
      .watchdog_clear_out(wdclr), .pc_reset_value_out(pc), .stack_pointer_out(sp),
      .timer0_control_out(t0c), .converter_control_out(cvc), .port_dir_out(pdir),
      .int_enable_clear_out());
   ext_reset_drv i_pin (.clk_in(clk_in), .req_in(pin_req), .pin_n_out(pin_n));
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      $display("compares=%0d mismatches=%0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge clk_in);
      s = 1'b0;
   endtask
   // Waits, bounded, until the core runs again.
   task automatic settle;
      for (n = 0; n < 2200 && (core_rst !== 1'b0 || halted !== 1'b0); n++) @(negedge clk_in);
      if (n == 2200) begin
         error_cnt++;
         give_verdict;
      end
   endtask
   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end
   initial begin
      {rst_in, wd, halt, wclr, wake, pin_req} = 6'b100000;
      repeat (10) @(negedge clk_in);
      rst_in = 1'b0;
      @(negedge clk_in);
      check({to, pd}, 2'b00);
      check(wdclr, 1'b1);
      repeat (1500) @(negedge clk_in);
      check(core_rst, 1'b1);
      settle;
      check(n, 24'd547);
      check(pc, 12'h000);
      check(sp, 3'h0);
      check(wdclr, 1'b0);
      check({t0c, cvc, pdir}, 24'h0840ff);
      $display("power-up done");
      for (i = 0; i < 7; i++) begin
         if (rows[i][4]) begin
            pulse(halt);
            check(halted, 1'b1);
         end
         case (rows[i][3:2])
            2'd0: pulse(wd);
            2'd1: pulse(pin_req);
            2'd2: pulse(wake);
            default: pulse(wclr);
         endcase
         repeat (12) @(negedge clk_in);
         settle;
         check({to, pd}, rows[i][1:0]);
         $display("row %0d done", i);
      end
      // A port wake-up costs the start-up delay only.
      pulse(halt);
      pulse(wake);
      settle;
      check(n, 24'd1024);
      check({to, pd}, 2'b01);
      $display("wake delay done");
      // Power-on reset in halt clears both flags, and events during the hold are ignored.
      pulse(halt);
      rst_in = 1'b1;
      repeat (3) @(negedge clk_in);
      rst_in = 1'b0;
      pulse(wd);
      check({to, pd, halted, core_rst}, 4'b0001);
      settle;
      check(n, 24'd2047);
      check({to, pd}, 2'b00);
      $display("reset in halt done");
      give_verdict;
   end
endmodule
bind reset_and_startup_control rsc_checker i_chk (.*);
`default_nettype wire
